// [pie_pkg.sv]
// Constants, register map and carrier types of the peripheral interrupt bank.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
// How it works
// - Enable bits read/write, reset zero, gate requests; enable 0 keeps only bits 0, 4 and 5, others read zero.
// - Flags set on events regardless of enables.
// - Pin-change flag is read-only OR of ports.
// - Timer0 overflow flag sets, holds until cleared.
// - External pin flag sets, holds until cleared.
// - Unused request bits read zero, ignore writes.
// - Receive flag follows receive buffer not empty.
// - Transmit flag follows transmit buffer empty.
// - Timer1 gate flag sets when gate closes.
// - Converter flag sets on conversion complete.
// - Sync port flag sets, holds until cleared.
// - Bus collision flag sets, holds until cleared.
// - Timer2 match flag sets, holds until cleared.
// - Timer1 overflow flag sets, holds until cleared.
// - Third enable register layout, clock and cells.
// - Fourth enable register layout, wavegens and capture.
// - Software may clear or set hardware flags except pin-change, receive and transmit.
// - All request flags read zero after reset.
// - Peripheral global enable gates the core request.
package pie_pkg;
   localparam int         ADDR_W        = 8;
   localparam int         DATA_W        = 32;
   localparam int         STRB_W        = 4;
   localparam int         REG_W         = 8;
   localparam logic [7:0] OFF_ENABLE_0  = 8'h00;
   localparam logic [7:0] OFF_ENABLE_1  = 8'h04;
   localparam logic [7:0] OFF_ENABLE_3  = 8'h08;
   localparam logic [7:0] OFF_ENABLE_4  = 8'h0C;
   localparam logic [7:0] OFF_REQUEST_0 = 8'h10;
   localparam logic [7:0] OFF_REQUEST_1 = 8'h14;
   localparam logic [7:0] OFF_REQUEST_3 = 8'h18;
   localparam logic [7:0] OFF_REQUEST_4 = 8'h1C;
   localparam logic [7:0] OFF_CONTROL   = 8'h20;
   localparam logic [7:0] OFF_STATUS    = 8'h24;
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [7:0] ALL_BITS      = 8'hFF;
   localparam logic [7:0] ENABLE_0_MASK = 8'h31;
   localparam logic [7:0] REQ0_WR_MASK  = 8'h21;
   localparam logic [7:0] REQ0_IMPL     = 8'h31;
   localparam logic [7:0] REQ1_WR_MASK  = 8'hCF;
   localparam int         REQ0_EXT_BIT  = 0;
   localparam int         REQ0_PCHG_BIT = 4;
   localparam int         REQ0_TMR0_BIT = 5;
   localparam int         REQ1_TMR1_BIT = 0;
   localparam int         REQ1_TMR2_BIT = 1;
   localparam int         REQ1_BCOL_BIT = 2;
   localparam int         REQ1_SYNC_BIT = 3;
   localparam int         REQ1_TX_BIT   = 4;
   localparam int         REQ1_RX_BIT   = 5;
   localparam int         REQ1_CONV_BIT = 6;
   localparam int         REQ1_GATE_BIT = 7;
   localparam int         CTRL_PEN_BIT  = 0;
   localparam int         STAT_IRQ_BIT  = 0;
   localparam int         STAT_ANY_BIT  = 1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } pie_wr_t;

   typedef struct packed {
      logic timer1_gate_lvl;
      logic conv_done;
      logic sync_port_evt;
      logic bus_collision;
      logic timer2_match;
      logic timer1_ovf;
   } pie_req1_evt_t;
endpackage : pie_pkg

// [pie_flag_bank.sv]
// One bank of request flags: writable bits latch events, others mirror levels.
// Assumes set inputs are synchronous to the clock.
module pie_flag_bank #(
   parameter int               WIDTH   = 8,
   parameter logic [WIDTH-1:0] WR_MASK = '1
) (
   // Clock and reset.
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   // Event sets and software write.
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             wr_en_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   // Flag state.
   output logic      [WIDTH-1:0] flags_out
);
   logic [WIDTH-1:0] flags_nxt;

   // Latched bits keep set over a clear in the same cycle.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      if (WR_MASK[i]) begin : g_rw
         assign flags_nxt[i] = set_in[i] |
            (wr_en_in ? wr_data_in[i] : flags_out[i]);
      end else begin : g_ro
         assign flags_nxt[i] = set_in[i];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         flags_out <= '0;
      end else begin
         flags_out <= flags_nxt;
      end
   end

   property p_set_wins;
      @(posedge clk_in) disable iff (!rst_b_in)
      ((set_in & WR_MASK) != '0) |=>
         ((flags_out & $past(set_in) & WR_MASK) ==
          ($past(set_in) & WR_MASK));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Hardware set lost.");

   property p_sw_write;
      @(posedge clk_in) disable iff (!rst_b_in)
      (wr_en_in && set_in == '0) |=>
         ((flags_out & WR_MASK) == ($past(wr_data_in) & WR_MASK));
   endproperty
   a_sw_write: assert property (p_sw_write)
      else $error("Software write not stored.");

   property p_reset_zero;
      @(posedge clk_in) disable iff (!rst_b_in)
      $rose(rst_b_in) |-> flags_out == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("Flags not zero after reset.");
endmodule : pie_flag_bank

// [pie_axil_port.sv]
// AXI4-Lite slave handshake; one write and one read in flight at a time.
// Assumes the parent decodes addresses combinationally and returns errors.
module pie_axil_port (
   // Clock and reset.
   input  wire logic                         clk_in,
   input  wire logic                         rst_b_in,
   // Write address and data.
   input  wire logic [pie_pkg::ADDR_W-1:0]   awaddr_in,
   input  wire logic                         awvalid_in,
   output logic                              awready_out,
   input  wire logic [pie_pkg::DATA_W-1:0]   wdata_in,
   input  wire logic [pie_pkg::STRB_W-1:0]   wstrb_in,
   input  wire logic                         wvalid_in,
   output logic                              wready_out,
   // Write response.
   output logic [1:0]                        bresp_out,
   output logic                              bvalid_out,
   input  wire logic                         bready_in,
   // Read address and data.
   input  wire logic                         arvalid_in,
   output logic                              arready_out,
   output logic [pie_pkg::DATA_W-1:0]        rdata_out,
   output logic [1:0]                        rresp_out,
   output logic                              rvalid_out,
   input  wire logic                         rready_in,
   // Register side.
   output pie_pkg::pie_wr_t                  wr_cmd_out,
   output logic                              wr_fire_out,
   input  wire logic                         wr_err_in,
   output logic                              ar_fire_out,
   input  wire logic [pie_pkg::DATA_W-1:0]   rd_data_in,
   input  wire logic                         rd_err_in
);
   logic aw_held_r;
   logic w_held_r;
   wire  aw_fire = awvalid_in & awready_out;
   wire  w_fire  = wvalid_in & wready_out;
   wire  b_done  = bvalid_out & bready_in;
   wire  r_done  = rvalid_out & rready_in;

   assign wr_fire_out = aw_held_r & w_held_r & ~bvalid_out;
   assign ar_fire_out = arvalid_in & arready_out;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         aw_held_r   <= 1'b0;
         w_held_r    <= 1'b0;
         awready_out <= 1'b1;
         wready_out  <= 1'b1;
         bvalid_out  <= 1'b0;
         bresp_out   <= pie_pkg::RESP_OKAY;
         wr_cmd_out  <= '0;
      end else begin
         if (aw_fire) begin
            aw_held_r       <= 1'b1;
            awready_out     <= 1'b0;
            wr_cmd_out.addr <= awaddr_in;
         end
         if (w_fire) begin
            w_held_r        <= 1'b1;
            wready_out      <= 1'b0;
            wr_cmd_out.data <= wdata_in;
            wr_cmd_out.strb <= wstrb_in;
         end
         if (wr_fire_out) begin
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            bvalid_out <= 1'b1;
            bresp_out  <= wr_err_in ? pie_pkg::RESP_SLVERR
                                    : pie_pkg::RESP_OKAY;
         end
         if (b_done) begin
            bvalid_out  <= 1'b0;
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         arready_out <= 1'b1;
         rvalid_out  <= 1'b0;
         rdata_out   <= '0;
         rresp_out   <= pie_pkg::RESP_OKAY;
      end else if (ar_fire_out) begin
         arready_out <= 1'b0;
         rvalid_out  <= 1'b1;
         rdata_out   <= rd_data_in;
         rresp_out   <= rd_err_in ? pie_pkg::RESP_SLVERR
                                  : pie_pkg::RESP_OKAY;
      end else if (r_done) begin
         arready_out <= 1'b1;
         rvalid_out  <= 1'b0;
      end
   end

   property p_bvalid_hold;
      @(posedge clk_in) disable iff (!rst_b_in)
      (bvalid_out && !bready_in) |=> bvalid_out && $stable(bresp_out);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("Write response dropped before taken.");

   property p_write_resp;
      @(posedge clk_in) disable iff (!rst_b_in)
      (awvalid_in && awready_out && wvalid_in && wready_out)
         |-> ##2 bvalid_out;
   endproperty
   a_write_resp: assert property (p_write_resp)
      else $error("Write response not two cycles after both taken.");
endmodule : pie_axil_port

// [pie_irq_bank.sv]
// Peripheral interrupt enable and request bank with an AXI4-Lite slave.
// Assumes event inputs are synchronous single-cycle pulses or levels.
module pie_irq_bank #(
   parameter int PIN_CHG_W = 3
) (
   // Clock and reset.
   input  wire logic                          CLK_IN,
   input  wire logic                          RST_B_IN,
   // AXI4-Lite write address and data.
   input  wire logic [pie_pkg::ADDR_W-1:0]    AWADDR_IN,
   input  wire logic                          AWVALID_IN,
   output logic                               AWREADY_OUT,
   input  wire logic [pie_pkg::DATA_W-1:0]    WDATA_IN,
   input  wire logic [pie_pkg::STRB_W-1:0]    WSTRB_IN,
   input  wire logic                          WVALID_IN,
   output logic                               WREADY_OUT,
   // AXI4-Lite write response.
   output logic [1:0]                         BRESP_OUT,
   output logic                               BVALID_OUT,
   input  wire logic                          BREADY_IN,
   // AXI4-Lite read.
   input  wire logic [pie_pkg::ADDR_W-1:0]    ARADDR_IN,
   input  wire logic                          ARVALID_IN,
   output logic                               ARREADY_OUT,
   output logic [pie_pkg::DATA_W-1:0]         RDATA_OUT,
   output logic [1:0]                         RRESP_OUT,
   output logic                               RVALID_OUT,
   input  wire logic                          RREADY_IN,
   // Request register 0 sources.
   input  wire logic                          TIMER0_OVF_IN,
   input  wire logic                          EXT_PIN_EVT_IN,
   input  wire logic [PIN_CHG_W-1:0]          PORT_PIN_CHANGE_FLAGS_IN,
   // Request register 1 sources.
   input  wire pie_pkg::pie_req1_evt_t        REQ1_EVT_IN,
   input  wire logic                          SERIAL_RX_READY_IN,
   input  wire logic                          SERIAL_TX_EMPTY_IN,
   // Request registers 3 and 4 sources, one pulse per bit.
   input  wire logic [pie_pkg::REG_W-1:0]     REQ3_EVT_IN,
   input  wire logic [pie_pkg::REG_W-1:0]     REQ4_EVT_IN,
   // Request to the processor core.
   output logic                               PERIPH_IRQ_OUT
);
   localparam int W = pie_pkg::REG_W;

   pie_pkg::pie_wr_t        wr_cmd;
   logic                    wr_fire;
   logic                    ar_fire;
   logic [W-1:0]            en0_r;
   logic [W-1:0]            en1_r;
   logic [W-1:0]            en3_r;
   logic [W-1:0]            en4_r;
   logic                    periph_en_r;
   logic                    gate_prev_r;
   logic [W-1:0]            req0;
   logic [W-1:0]            req1;
   logic [W-1:0]            req3;
   logic [W-1:0]            req4;
   logic [pie_pkg::DATA_W-1:0] rd_data;

   // Write decode.
   wire [W-1:0] wr_byte  = wr_cmd.data[W-1:0];
   wire         wr_lane0 = wr_fire & wr_cmd.strb[0];
   wire [5:0]   wr_word  = wr_cmd.addr[pie_pkg::ADDR_W-1:2];
   wire w_en0  = wr_word == pie_pkg::OFF_ENABLE_0[7:2];
   wire w_en1  = wr_word == pie_pkg::OFF_ENABLE_1[7:2];
   wire w_en3  = wr_word == pie_pkg::OFF_ENABLE_3[7:2];
   wire w_en4  = wr_word == pie_pkg::OFF_ENABLE_4[7:2];
   wire w_req0 = wr_word == pie_pkg::OFF_REQUEST_0[7:2];
   wire w_req1 = wr_word == pie_pkg::OFF_REQUEST_1[7:2];
   wire w_req3 = wr_word == pie_pkg::OFF_REQUEST_3[7:2];
   wire w_req4 = wr_word == pie_pkg::OFF_REQUEST_4[7:2];
   wire w_ctrl = wr_word == pie_pkg::OFF_CONTROL[7:2];
   wire w_stat = wr_word == pie_pkg::OFF_STATUS[7:2];
   wire wr_hit = w_en0 | w_en1 | w_en3 | w_en4 | w_req0 | w_req1 |
                 w_req3 | w_req4 | w_ctrl | w_stat;

   // Read decode.
   wire [5:0] rd_word = ARADDR_IN[pie_pkg::ADDR_W-1:2];
   wire r_en0  = rd_word == pie_pkg::OFF_ENABLE_0[7:2];
   wire r_en1  = rd_word == pie_pkg::OFF_ENABLE_1[7:2];
   wire r_en3  = rd_word == pie_pkg::OFF_ENABLE_3[7:2];
   wire r_en4  = rd_word == pie_pkg::OFF_ENABLE_4[7:2];
   wire r_req0 = rd_word == pie_pkg::OFF_REQUEST_0[7:2];
   wire r_req1 = rd_word == pie_pkg::OFF_REQUEST_1[7:2];
   wire r_req3 = rd_word == pie_pkg::OFF_REQUEST_3[7:2];
   wire r_req4 = rd_word == pie_pkg::OFF_REQUEST_4[7:2];
   wire r_ctrl = rd_word == pie_pkg::OFF_CONTROL[7:2];
   wire r_stat = rd_word == pie_pkg::OFF_STATUS[7:2];
   wire rd_hit = r_en0 | r_en1 | r_en3 | r_en4 | r_req0 | r_req1 |
                 r_req3 | r_req4 | r_ctrl | r_stat;

   // Event shaping into set vectors.
   wire gate_lvl   = REQ1_EVT_IN.timer1_gate_lvl;
   wire gate_close = gate_prev_r & ~gate_lvl;
   wire pchg_or    = |PORT_PIN_CHANGE_FLAGS_IN;

   wire [W-1:0] req0_set =
      (W'(TIMER0_OVF_IN)  << pie_pkg::REQ0_TMR0_BIT) |
      (W'(pchg_or)        << pie_pkg::REQ0_PCHG_BIT) |
      (W'(EXT_PIN_EVT_IN) << pie_pkg::REQ0_EXT_BIT);

   wire [W-1:0] req1_set =
      (W'(gate_close)                << pie_pkg::REQ1_GATE_BIT) |
      (W'(REQ1_EVT_IN.conv_done)     << pie_pkg::REQ1_CONV_BIT) |
      (W'(SERIAL_RX_READY_IN)        << pie_pkg::REQ1_RX_BIT) |
      (W'(SERIAL_TX_EMPTY_IN)        << pie_pkg::REQ1_TX_BIT) |
      (W'(REQ1_EVT_IN.sync_port_evt) << pie_pkg::REQ1_SYNC_BIT) |
      (W'(REQ1_EVT_IN.bus_collision) << pie_pkg::REQ1_BCOL_BIT) |
      (W'(REQ1_EVT_IN.timer2_match)  << pie_pkg::REQ1_TMR2_BIT) |
      (W'(REQ1_EVT_IN.timer1_ovf)    << pie_pkg::REQ1_TMR1_BIT);

   // Combined request before the peripheral global enable.
   wire irq_any = |(req0 & en0_r) | |(req1 & en1_r) |
                  |(req3 & en3_r) | |(req4 & en4_r);

   // Read data selection.
   wire [W-1:0] rd_byte =
      r_en0  ? en0_r :
      r_en1  ? en1_r :
      r_en3  ? en3_r :
      r_en4  ? en4_r :
      r_req0 ? req0 :
      r_req1 ? req1 :
      r_req3 ? req3 :
      r_req4 ? req4 :
      r_ctrl ? (W'(periph_en_r) << pie_pkg::CTRL_PEN_BIT) :
      r_stat ? ((W'(PERIPH_IRQ_OUT) << pie_pkg::STAT_IRQ_BIT) |
                (W'(irq_any) << pie_pkg::STAT_ANY_BIT)) :
      pie_pkg::RESET_BYTE;
   assign rd_data = {{(pie_pkg::DATA_W-W){1'b0}}, rd_byte};

   pie_axil_port u_port (
      .clk_in      (CLK_IN),
      .rst_b_in    (RST_B_IN),
      .awaddr_in   (AWADDR_IN),
      .awvalid_in  (AWVALID_IN),
      .awready_out (AWREADY_OUT),
      .wdata_in    (WDATA_IN),
      .wstrb_in    (WSTRB_IN),
      .wvalid_in   (WVALID_IN),
      .wready_out  (WREADY_OUT),
      .bresp_out   (BRESP_OUT),
      .bvalid_out  (BVALID_OUT),
      .bready_in   (BREADY_IN),
      .arvalid_in  (ARVALID_IN),
      .arready_out (ARREADY_OUT),
      .rdata_out   (RDATA_OUT),
      .rresp_out   (RRESP_OUT),
      .rvalid_out  (RVALID_OUT),
      .rready_in   (RREADY_IN),
      .wr_cmd_out  (wr_cmd),
      .wr_fire_out (wr_fire),
      .wr_err_in   (~wr_hit),
      .ar_fire_out (ar_fire),
      .rd_data_in  (rd_data),
      .rd_err_in   (~rd_hit)
   );

   pie_flag_bank #(.WIDTH(W), .WR_MASK(pie_pkg::REQ0_WR_MASK)) u_req0 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .set_in     (req0_set),
      .wr_en_in   (wr_lane0 & w_req0),
      .wr_data_in (wr_byte),
      .flags_out  (req0)
   );

   pie_flag_bank #(.WIDTH(W), .WR_MASK(pie_pkg::REQ1_WR_MASK)) u_req1 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .set_in     (req1_set),
      .wr_en_in   (wr_lane0 & w_req1),
      .wr_data_in (wr_byte),
      .flags_out  (req1)
   );

   pie_flag_bank #(.WIDTH(W), .WR_MASK(pie_pkg::ALL_BITS)) u_req3 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .set_in     (REQ3_EVT_IN),
      .wr_en_in   (wr_lane0 & w_req3),
      .wr_data_in (wr_byte),
      .flags_out  (req3)
   );

   pie_flag_bank #(.WIDTH(W), .WR_MASK(pie_pkg::ALL_BITS)) u_req4 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .set_in     (REQ4_EVT_IN),
      .wr_en_in   (wr_lane0 & w_req4),
      .wr_data_in (wr_byte),
      .flags_out  (req4)
   );

   // Enable and control registers.
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         en0_r       <= pie_pkg::RESET_BYTE;
         en1_r       <= pie_pkg::RESET_BYTE;
         en3_r       <= pie_pkg::RESET_BYTE;
         en4_r       <= pie_pkg::RESET_BYTE;
         periph_en_r <= 1'b0;
      end else if (wr_lane0) begin
         if (w_en0) begin
            en0_r <= wr_byte & pie_pkg::ENABLE_0_MASK;
         end
         if (w_en1) begin
            en1_r <= wr_byte;
         end
         if (w_en3) begin
            en3_r <= wr_byte;
         end
         if (w_en4) begin
            en4_r <= wr_byte;
         end
         if (w_ctrl) begin
            periph_en_r <= wr_byte[pie_pkg::CTRL_PEN_BIT];
         end
      end
   end

   // Gate history and the registered core request.
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         gate_prev_r    <= 1'b0;
         PERIPH_IRQ_OUT <= 1'b0;
      end else begin
         gate_prev_r    <= gate_lvl;
         PERIPH_IRQ_OUT <= periph_en_r & irq_any;
      end
   end

   property p_en3_write;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (wr_lane0 && w_en3) |=> en3_r == $past(wr_byte);
   endproperty
   a_en3_write: assert property (p_en3_write)
      else $error("Enable write not stored.");

   property p_ext_flag;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      EXT_PIN_EVT_IN |=> req0[pie_pkg::REQ0_EXT_BIT];
   endproperty
   a_ext_flag: assert property (p_ext_flag)
      else $error("External pin flag not set.");

   property p_tmr0_flag;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      TIMER0_OVF_IN |=> req0[pie_pkg::REQ0_TMR0_BIT];
   endproperty
   a_tmr0_flag: assert property (p_tmr0_flag)
      else $error("Timer0 overflow flag not set.");

   property p_pchg;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      $past(RST_B_IN) |-> req0[pie_pkg::REQ0_PCHG_BIT] == $past(pchg_or);
   endproperty
   a_pchg: assert property (p_pchg)
      else $error("Pin-change flag differs from port OR.");

   property p_req0_unused;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (req0 & ~pie_pkg::REQ0_IMPL) == pie_pkg::RESET_BYTE;
   endproperty
   a_req0_unused: assert property (p_req0_unused)
      else $error("Unused request bit reads one.");

   property p_rx;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      $past(RST_B_IN) |->
         req1[pie_pkg::REQ1_RX_BIT] == $past(SERIAL_RX_READY_IN);
   endproperty
   a_rx: assert property (p_rx)
      else $error("Receive flag not following buffer.");

   property p_tx;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      $past(RST_B_IN) |->
         req1[pie_pkg::REQ1_TX_BIT] == $past(SERIAL_TX_EMPTY_IN);
   endproperty
   a_tx: assert property (p_tx)
      else $error("Transmit flag not following buffer.");

   property p_gate;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      ($past(RST_B_IN) && $fell(gate_lvl)) |=> req1[pie_pkg::REQ1_GATE_BIT];
   endproperty
   a_gate: assert property (p_gate)
      else $error("Gate close did not set flag.");

   property p_pen_off;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      !periph_en_r |=> !PERIPH_IRQ_OUT;
   endproperty
   a_pen_off: assert property (p_pen_off)
      else $error("Request raised with peripheral enable off.");

   property p_irq;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      $past(RST_B_IN) |-> PERIPH_IRQ_OUT == $past(periph_en_r && irq_any);
   endproperty
   a_irq: assert property (p_irq)
      else $error("Core request does not match flags and enables.");

   property p_conv;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      REQ1_EVT_IN.conv_done |=> req1[pie_pkg::REQ1_CONV_BIT];
   endproperty
   a_conv: assert property (p_conv)
      else $error("Converter flag lost.");

   property p_sync;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      REQ1_EVT_IN.sync_port_evt |=> req1[pie_pkg::REQ1_SYNC_BIT];
   endproperty
   a_sync: assert property (p_sync)
      else $error("Sync port flag lost.");

   property p_bcol;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      REQ1_EVT_IN.bus_collision |=> req1[pie_pkg::REQ1_BCOL_BIT];
   endproperty
   a_bcol: assert property (p_bcol)
      else $error("Collision flag lost.");

   property p_tmr2;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      REQ1_EVT_IN.timer2_match |=> req1[pie_pkg::REQ1_TMR2_BIT];
   endproperty
   a_tmr2: assert property (p_tmr2)
      else $error("Timer2 flag lost.");

   property p_tmr1;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      REQ1_EVT_IN.timer1_ovf |=> req1[pie_pkg::REQ1_TMR1_BIT];
   endproperty
   a_tmr1: assert property (p_tmr1)
      else $error("Timer1 flag lost.");

   c_irq: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      $rose(PERIPH_IRQ_OUT));
   c_clear: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      wr_lane0 && w_req1 && wr_byte == pie_pkg::RESET_BYTE);
   c_gate: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      gate_close);
   c_read: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
      ar_fire && r_req0);
endmodule : pie_irq_bank

// [pie_evt_src.sv]
// Event source model that stands beside the peripheral interrupt bank.
// Assumes the testbench issues one event code per clock while fire is high.
module pie_evt_src (
   // Clock and command.
   input  wire logic              clk_in,
   input  wire logic              fire_in,
   input  wire logic [4:0]        code_in,
   // Event outputs.
   output logic                   t0_out,
   output logic                   ext_out,
   output pie_pkg::pie_req1_evt_t ev1_out,
   output logic [15:0]            ev34_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] hot;
   assign hot = fire_in ? (32'h1 << code_in) : 32'h0;
   initial begin
      {ev34_out, ev1_out, ext_out, t0_out} = '0;
   end
   // Codes 0 to 6 drive pulses, 7 toggles the gate, 8 to 23 pulse banks 3/4.
   always @(posedge clk_in) begin
      {ev34_out, ev1_out[4:0], ext_out, t0_out} <= {hot[23:8], hot[6:0]};
      if (hot[7]) ev1_out.timer1_gate_lvl <= ~ev1_out.timer1_gate_lvl;
   end
endmodule : pie_evt_src

// [pie_irq_bank_test.sv]
// Self-checking testbench for the peripheral interrupt bank.
// Assumes the event source model drives all pulse inputs.
module pie_irq_bank_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0;
   logic        brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, fire = 1'b0;
   logic        rx = 1'b0, tx = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, got, rdata;
   logic [4:0]  code = 5'h00;
   logic [2:0]  pins = 3'h0;
   logic [1:0]  bresp, rresp, rsp;
   logic        awr, wrdy, bv, arr, rv, irq, t0, ext;
   logic [15:0] ev34;
   pie_pkg::pie_req1_evt_t ev1;
   int          num_errors = 0, comparisons = 0;
   // Rows: address, write byte, expected read byte, expected response.
   logic [25:0] rows [13] = '{{8'h08, 8'hFF, 8'hFF, 2'h0},
      {8'h0C, 8'hA5, 8'hA5, 2'h0}, {8'h00, 8'hFF, 8'h31, 2'h0},
      {8'h04, 8'h5A, 8'h5A, 2'h0}, {8'h10, 8'hFF, 8'h21, 2'h0},
      {8'h10, 8'h00, 8'h00, 2'h0}, {8'h14, 8'hFF, 8'hCF, 2'h0},
      {8'h14, 8'h00, 8'h00, 2'h0}, {8'h30, 8'hFF, 8'h00, 2'h2},
      {8'h08, 8'h00, 8'h00, 2'h0}, {8'h0C, 8'h00, 8'h00, 2'h0},
      {8'h00, 8'h00, 8'h00, 2'h0}, {8'h04, 8'h00, 8'h00, 2'h0}};
   always #50 clk = ~clk;
   pie_irq_bank u_pie_irq_bank (.CLK_IN(clk), .RST_B_IN(rst_b),
      .AWADDR_IN(awaddr), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wdata), .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wrdy),
      .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(brdy),
      .ARADDR_IN(araddr), .ARVALID_IN(arv), .ARREADY_OUT(arr),
      .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rrdy),
      .TIMER0_OVF_IN(t0), .EXT_PIN_EVT_IN(ext), .PORT_PIN_CHANGE_FLAGS_IN(pins),
      .REQ1_EVT_IN(ev1), .SERIAL_RX_READY_IN(rx), .SERIAL_TX_EMPTY_IN(tx),
      .REQ3_EVT_IN(ev34[7:0]), .REQ4_EVT_IN(ev34[15:8]), .PERIPH_IRQ_OUT(irq));
   pie_evt_src u_pie_evt_src (.clk_in(clk), .fire_in(fire), .code_in(code),
      .t0_out(t0), .ext_out(ext), .ev1_out(ev1), .ev34_out(ev34));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      rsp = bresp;
      brdy <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      got = rdata;
      rsp = rresp;
      rrdy <= 1'b0;
   endtask : rd
   task automatic stop_test;
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(8'(4 * i));
         chk(got, 32'h0);
      end
      foreach (rows[i]) begin
         wr(rows[i][25:18], rows[i][17:10]);
         chk({30'h0, rsp}, {30'h0, rows[i][1:0]});
         rd(rows[i][25:18]);
         chk(got, {24'h0, rows[i][9:2]});
         chk({30'h0, rsp}, {30'h0, rows[i][1:0]});
      end
      for (int c = 0; c < 25; c++) begin
         @(posedge clk);
         fire <= 1'b1;
         code <= (c == 24) ? 5'h07 : 5'(c);
      end
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(8'h10);
      chk(got, 32'h21);
      rd(8'h14);
      chk(got, 32'hCF);
      rd(8'h18);
      chk(got, 32'hFF);
      rd(8'h1C);
      chk(got, 32'hFF);
      wr(8'h08, 8'h01);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(8'h20, 8'h01);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(8'h18, 8'hFE);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      pins <= 3'h2;
      rx <= 1'b1;
      tx <= 1'b1;
      wr(8'h10, 8'h00);
      wr(8'h14, 8'h00);
      rd(8'h10);
      chk(got, 32'h10);
      rd(8'h14);
      chk(got, 32'h30);
      pins <= 3'h0;
      rx <= 1'b0;
      rd(8'h14);
      chk(got, 32'h10);
      rd(8'h10);
      chk(got, 32'h0);
      wr(8'h1C, 8'h00);
      wr(8'h0C, 8'h01);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      fire <= 1'b1;
      code <= 5'h10;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd(8'h24);
      chk(got, 32'h3);
      rst_b <= 1'b0;
      tx <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h08);
      chk(got, 32'h0);
      rd(8'h1C);
      chk(got, 32'h0);
      stop_test;
   end
endmodule : pie_irq_bank_test
